// [hdl/wdslp_pkg.sv]
// Purpose: constants and types for the watchdog, sleep and wake control
// Assumes: one clock mclk, synchronous active-high reset srst
// Notes: cpu status image sits at offset 0x06, 8 bits wide
// Behaviour
// - counter and postscaler time the power-up delay during power-on reset
// - plain timer mode counts on the main device clock
// - software has no read or write path to counter or postscaler
// - plain timer overflows after 65536 oscillator periods
// - plain timer overflow clears time-out flag, no reset
// - clear-watchdog instruction sets time-out flag back to one
// - plain timer holds its value while asleep
// - sleep instruction enters power-down and clears counter and postscaler
// - entering sleep clears power-down flag and sets time-out flag
// - sleep stops oscillator driver; ports keep their prior drive state
// - watchdog reset is internal, never pulls master clear pin low
// - wake on por, master clear, watchdog, int pin, port change, timer0 pin
// - only listed peripheral interrupts may wake from sleep
// - reset wake does full reset; interrupt wake continues execution
// - power-down flag set at power-up; time-out flag cleared by watchdog wake
// - sleep instruction prefetches the next program address
// - wake needs source enable; global disable bit does not matter
// - after interrupt wake run prefetched instruction, then vector if enabled
// - pending enabled interrupt at sleep wakes at once, to set, pd clear
// - watchdog counter cleared on every wake
// - crystal modes hold reset 1024 periods on interrupt wake; none in rc mode
// - code protection active when processor mode select is 000
// - protected mode blocks table access from code outside internal memory
// - watchdog disabled when period select is 00
package wdslp_pkg;
  localparam logic [7:0] CPU_STATUS_OFS = 8'h06;
  localparam logic [7:0] CPU_STATUS_RST = 8'h3C;
  localparam int STACK_AVAILABLE_FLAG_BIT = 5;
  localparam int GLOBAL_INT_DISABLE_BIT = 4;
  localparam int TO_BIT = 3;
  localparam int PD_BIT = 2;
  localparam int POR_BIT = 1;
  localparam int BOR_BIT = 0;
  localparam logic [1:0] WPS_DISABLED = 2'h0;
  localparam logic [1:0] WPS_TIMER = 2'h1;
  localparam logic [2:0] PM_PROTECTED = 3'h0;
  localparam logic [1:0] OSC_LF = 2'h0;
  localparam logic [1:0] OSC_XT = 2'h1;
  localparam logic [1:0] OSC_RC = 2'h3;
  localparam int TIMER_PERIODS = 65536;
  localparam int OST_PERIODS = 1024;
  localparam int WDT_W = 16;
  localparam int PS_W = 8;
  localparam int OST_W = 11;
  localparam int PWRT_PERIODS = 4096;
  localparam logic [WDT_W-1:0] WDT_MAX = 16'hFFFF;
  localparam logic [WDT_W-1:0] PWRT_LAST =
    WDT_W'(PWRT_PERIODS - 1);
  localparam logic [OST_W-1:0] OST_LAST =
    OST_W'(OST_PERIODS - 1);
  localparam int PERIPH_N = 6;
  typedef enum logic [2:0] {
    WDSLP_RESET = 3'b000,
    WDSLP_RUN = 3'b001,
    WDSLP_SLEEP = 3'b011,
    WDSLP_OST = 3'b010,
    WDSLP_PREF = 3'b110
  } wdslp_state_t;
endpackage

// [hdl/wdslp_ctr_if.sv]
// Purpose: carries counter control between top and counter
// Assumes: one clock domain
// Notes: none
interface wdslp_ctr_if;
  logic clr;
  logic inc;
  logic [15:0] value;
  logic ovf;
  modport ctl (output clr, output inc, input value, input ovf);
  modport ctr (input clr, input inc, output value, output ovf);
endinterface

// [hdl/wdslp_counter.sv]
// Purpose: watchdog counter plus postscaler as one clearable count
// Assumes: inc is a one-cycle enable
// Notes: ovf pulses when the 16-bit count wraps
module wdslp_counter
  import wdslp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // control
  wdslp_ctr_if.ctr c
);
  logic [WDT_W-1:0] cnt_r;
  logic ovf_r;
  // counter, clear beats increment
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_r <= '0;
      ovf_r <= 1'b0;
    end else if (ce) begin
      ovf_r <= 1'b0;
      if (c.clr) begin
        cnt_r <= '0;
      end else if (c.inc) begin
        cnt_r <= cnt_r + 1'b1;
        ovf_r <= (cnt_r == WDT_MAX);
      end
    end
  end
  assign c.value = cnt_r;
  assign c.ovf = ovf_r;
endmodule

// [hdl/wdslp_top.sv]
// Purpose: watchdog as plain timer, sleep entry, wake and table gating
// Assumes: core pulses instr_* one cycle; inputs synchronous to mclk
// Notes: counter value is never visible on the register port
module wdslp_top
  import wdslp_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // reset sources
  input wire logic por_evt,
  input wire logic bor_evt,
  input wire logic mclr_evt,
  input wire logic wdt_reset_evt,
  // configuration fields
  input wire logic [1:0] watchdog_period_select,
  input wire logic [2:0] processor_mode_select,
  input wire logic [1:0] osc_mode,
  // core instructions
  input wire logic clear_watchdog_instr,
  input wire logic sleep_instr,
  input wire logic [15:0] pc,
  // interrupt sources: flags and enables
  input wire logic int_pin_flag,
  input wire logic int_pin_en,
  input wire logic rb_change_flag,
  input wire logic rb_change_en,
  input wire logic timer0_clock_input_flag,
  input wire logic timer0_clock_input_en,
  input wire logic [PERIPH_N-1:0] periph_wake_flag,
  input wire logic [PERIPH_N-1:0] periph_wake_en,
  input wire logic stack_available_flag,
  // table access
  input wire logic table_req,
  input wire logic fetch_internal,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // outputs to core and pads
  output logic device_reset,
  output logic sleeping,
  output logic osc_drive_en,
  output logic prefetch_en,
  output logic [15:0] prefetch_addr,
  output logic vector_take,
  output logic table_grant,
  output logic code_protected,
  output logic timer_overflow,
  output logic mclr_pull_oe
);
  wdslp_ctr_if cif ();
  wdslp_counter u_ctr (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .c(cif)
  );

  wdslp_state_t state_r, state_nxt;
  logic timeout_flag_r, powerdown_flag_r, global_int_disable_r;
  logic por_flag_r, bor_flag_r;
  logic [OST_W-1:0] ost_r;
  logic wdt_off, timer_mode, int_wake, wake_any, crystal, rst_evt;

  // pending, enabled sources; global disable deliberately ignored
  function automatic logic wake_pending(input logic [8:0] f,
                                        input logic [8:0] e);
    return |(f & e);
  endfunction

  assign wdt_off = (watchdog_period_select == WPS_DISABLED);
  assign timer_mode = (watchdog_period_select == WPS_TIMER);
  assign crystal = (osc_mode == OSC_XT) || (osc_mode == OSC_LF);
  // only listed wake-capable peripherals are wired in
  assign int_wake = wake_pending({int_pin_flag, rb_change_flag, timer0_clock_input_flag,
                                  periph_wake_flag},
                                 {int_pin_en, rb_change_en, timer0_clock_input_en,
                                  periph_wake_en});
  assign wake_any = int_wake;
  // a disabled watchdog cannot restart the device
  assign rst_evt = por_evt || bor_evt || mclr_evt ||
                   (wdt_reset_evt && !wdt_off);

  // state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      WDSLP_RESET: begin
        // power-up delay timed on the shared counter and postscale
        if (cif.value == PWRT_LAST) state_nxt = WDSLP_RUN;
      end
      WDSLP_RUN: begin
        if (sleep_instr) begin
          if (wake_any) state_nxt = WDSLP_PREF;
          else state_nxt = WDSLP_SLEEP;
        end
      end
      WDSLP_SLEEP: begin
        if (wake_any) begin
          state_nxt = crystal ? WDSLP_OST : WDSLP_PREF;
        end
      end
      WDSLP_OST: begin
        if (ost_r == OST_LAST) state_nxt = WDSLP_PREF;
      end
      WDSLP_PREF: state_nxt = WDSLP_RUN;
      default: state_nxt = WDSLP_RESET;
    endcase
    // reset sources win from any state so the outputs follow at once
    if (rst_evt) state_nxt = WDSLP_RESET;
  end

  // state register; reset events are already folded into state_nxt
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= WDSLP_RESET;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // start-up timer runs only in its own state
  always_ff @(posedge mclk) begin
    if (srst) begin
      ost_r <= '0;
    end else if (ce) begin
      if (state_r == WDSLP_OST) ost_r <= ost_r + 1'b1;
      else ost_r <= '0;
    end
  end

  // counter steering: the core has no path to the value
  always_comb begin
    cif.clr = clear_watchdog_instr || sleep_instr
           || (state_r == WDSLP_SLEEP && wake_any)
           || (state_r == WDSLP_RUN && !timer_mode)
           // restart on any reset, fresh count once reset ends
           || rst_evt
           || (state_r == WDSLP_RESET && state_nxt != WDSLP_RESET);
    // counts mclk, frozen asleep
    cif.inc = (state_r == WDSLP_RESET) ||
              (state_r == WDSLP_RUN && timer_mode);
  end

  // status flags; an overflow beats a same-cycle clear instruction
  always_ff @(posedge mclk) begin
    if (srst) begin
      timeout_flag_r <= CPU_STATUS_RST[TO_BIT];
      powerdown_flag_r <= CPU_STATUS_RST[PD_BIT];
      global_int_disable_r <= CPU_STATUS_RST[GLOBAL_INT_DISABLE_BIT];
      por_flag_r <= 1'b0;
      bor_flag_r <= 1'b0;
    end else if (ce) begin
      if (por_evt) begin
        timeout_flag_r <= 1'b1;
        powerdown_flag_r <= 1'b1;
        global_int_disable_r <= 1'b1;
        por_flag_r <= 1'b0;
        bor_flag_r <= 1'b0;
      end else begin
        if (reg_wr && reg_addr == CPU_STATUS_OFS) begin
          global_int_disable_r <= reg_wdata[GLOBAL_INT_DISABLE_BIT];
          // software may only set the power-on/brown-out indicators
          por_flag_r <= por_flag_r | reg_wdata[POR_BIT];
          bor_flag_r <= bor_flag_r | reg_wdata[BOR_BIT];
        end
        if (bor_evt) bor_flag_r <= 1'b0;
        if (wdt_reset_evt && !wdt_off && state_r == WDSLP_SLEEP)
          timeout_flag_r <= 1'b0;
        else if (cif.ovf && state_r == WDSLP_RUN)
          timeout_flag_r <= 1'b0;
        else if (clear_watchdog_instr)
          timeout_flag_r <= 1'b1;
        else if (state_r == WDSLP_RUN && sleep_instr) begin
          timeout_flag_r <= 1'b1;
        end
        if (state_r == WDSLP_RUN && sleep_instr)
          powerdown_flag_r <= 1'b0;
        else if (clear_watchdog_instr)
          powerdown_flag_r <= 1'b1;
      end
    end
  end

  // register read, one cycle later; counter value never mapped
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      if (reg_rd && reg_addr == CPU_STATUS_OFS)
        reg_rdata <= {2'b00, stack_available_flag, global_int_disable_r,
                      timeout_flag_r, powerdown_flag_r, por_flag_r,
                      bor_flag_r};
      else
        reg_rdata <= 8'h00;
    end
  end

  // core-facing outputs, all registered
  always_ff @(posedge mclk) begin
    if (srst) begin
      device_reset <= 1'b1;
      sleeping <= 1'b0;
      osc_drive_en <= 1'b1;
      prefetch_en <= 1'b0;
      prefetch_addr <= 16'h0000;
      vector_take <= 1'b0;
      timer_overflow <= 1'b0;
      mclr_pull_oe <= 1'b0;
    end else if (ce) begin
      // start-up timer holds the device in reset
      device_reset <= (state_nxt == WDSLP_RESET) ||
                      (state_nxt == WDSLP_OST);
      sleeping <= (state_nxt == WDSLP_SLEEP);
      // ports are untouched here, only the oscillator stops
      osc_drive_en <= (state_nxt != WDSLP_SLEEP);
      prefetch_en <= (state_r == WDSLP_RUN && sleep_instr) ||
                     (state_nxt == WDSLP_PREF);
      if (state_r == WDSLP_RUN && sleep_instr)
        prefetch_addr <= pc + 16'h0001;
      vector_take <= (state_r == WDSLP_PREF) &&
                     !global_int_disable_r;
      timer_overflow <= cif.ovf && (state_r == WDSLP_RUN);
      mclr_pull_oe <= 1'b0;
    end
  end

  // table access gate
  always_ff @(posedge mclk) begin
    if (srst) begin
      table_grant <= 1'b0;
      code_protected <= 1'b0;
    end else if (ce) begin
      code_protected <= (processor_mode_select == PM_PROTECTED);
      table_grant <= table_req &&
        (processor_mode_select != PM_PROTECTED || fetch_internal);
    end
  end
endmodule

// [sim/wdslp_props.sv]
// Purpose: port checker for watchdog, sleep and wake control
// Assumes: single clock mclk, srst synchronous active high
// Notes: bound into wdslp_top, watches its ports only
module wdslp_props
  import wdslp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // inputs watched
  input wire logic wdt_reset_evt,
  input wire logic [1:0] watchdog_period_select,
  input wire logic [2:0] processor_mode_select,
  input wire logic sleep_instr,
  input wire logic [15:0] pc,
  input wire logic table_req,
  input wire logic fetch_internal,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  // outputs watched
  input wire logic [7:0] reg_rdata,
  input wire logic device_reset,
  input wire logic sleeping,
  input wire logic osc_drive_en,
  input wire logic prefetch_en,
  input wire logic [15:0] prefetch_addr,
  input wire logic table_grant,
  input wire logic timer_overflow,
  input wire logic mclr_pull_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // sleep taken only while the core runs
  sequence s_sleep_go;
    ce && sleep_instr && !device_reset && !sleeping;
  endsequence
  sequence s_prefetch;
    prefetch_en && prefetch_addr == 16'($past(pc) + 16'h0001);
  endsequence
  AST_PREFETCH: assert property (s_sleep_go |=> s_prefetch)
    else $error("no prefetch of next address after sleep");
  AST_OSC_OFF: assert property (sleeping |-> !osc_drive_en)
    else $error("oscillator driven while asleep");
  AST_NO_MCLR: assert property (!mclr_pull_oe)
    else $error("master clear pin driven");
  AST_TBL_OK: assert property (ce && table_req &&
    (processor_mode_select != PM_PROTECTED || fetch_internal) |=> table_grant)
    else $error("table access refused");
  AST_TBL_BLK: assert property (ce && table_req &&
    processor_mode_select == PM_PROTECTED && !fetch_internal |=> !table_grant)
    else $error("table access from outside granted");
  AST_UNMAPPED: assert property (ce && reg_rd &&
    reg_addr != CPU_STATUS_OFS |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_ASLEEP_HOLD: assert property (sleeping |-> !timer_overflow)
    else $error("timer overflow while asleep");
  AST_TMR_MODE: assert property (timer_overflow |->
    $past(watchdog_period_select, 2) == WPS_TIMER)
    else $error("overflow outside timer mode");
  AST_WDT_OFF: assert property (ce && wdt_reset_evt &&
    watchdog_period_select == WPS_DISABLED && !device_reset |=> !device_reset)
    else $error("disabled watchdog reset the device");
endmodule

bind wdslp_top wdslp_props u_props (.*);

// [sim/test_watchdog_sleep_wake_control.sv]
// Purpose: self-checking bench for wdslp_top
// Assumes: 10 MHz mclk, power-up delay of PWRT_PERIODS counts
// Notes: the plain timer period dominates the run length
module test_watchdog_sleep_wake_control
  import wdslp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, srst, ce, por_evt, bor_evt, mclr_evt, wdt_reset_evt;
  logic [1:0] watchdog_period_select, osc_mode;
  logic [2:0] processor_mode_select;
  logic clear_watchdog_instr, sleep_instr, stack_available_flag;
  logic [15:0] pc, prefetch_addr;
  logic int_pin_flag, int_pin_en, rb_change_flag, rb_change_en;
  logic timer0_clock_input_flag, timer0_clock_input_en, table_req, fetch_internal, reg_wr, reg_rd;
  logic [PERIPH_N-1:0] periph_wake_flag, periph_wake_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic device_reset, sleeping, osc_drive_en, prefetch_en, vector_take;
  logic table_grant, code_protected, timer_overflow, mclr_pull_oe;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  int comparisons = 0;
  int n_fail = 0;

  wdslp_top dut (.*);

  // clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  localparam int P_CLR = 0, P_SLP = 1, P_WDT = 2, P_MCLR = 3;
  // one-cycle strobe on one of the core or reset inputs
  task automatic pulse(input int w);
    @(posedge mclk);
    {mclr_evt, wdt_reset_evt, sleep_instr, clear_watchdog_instr} <= 4'h1 << w;
    @(posedge mclk);
    {mclr_evt, wdt_reset_evt, sleep_instr, clear_watchdog_instr} <= 4'h0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // expected read data queued when the read is issued
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  // bounded wait, n counts edges until high
  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (s !== 1'b1 && n < lim);
  endtask
  task automatic conclude();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // read data stands one cycle after the strobe
  always @(posedge mclk) rd_seen <= reg_rd;
  always @(negedge mclk)
    if (rd_seen) chk("rdata", exp_q.pop_front(), reg_rdata);
  // hang guard, run needs about 7.5 ms
  initial begin
    #10_000_000;
    n_fail++;
    conclude();
  end
  initial begin
    int n;
    {srst, ce, stack_available_flag} = 3'b111;
    {por_evt, bor_evt, mclr_evt, wdt_reset_evt, sleep_instr} = '0;
    {clear_watchdog_instr, table_req, fetch_internal, reg_wr, reg_rd} = '0;
    {int_pin_flag, int_pin_en, rb_change_flag, rb_change_en} = '0;
    {timer0_clock_input_flag, timer0_clock_input_en, periph_wake_flag, periph_wake_en} = '0;
    {pc, reg_addr, reg_wdata} = '0;
    watchdog_period_select = WPS_TIMER;
    processor_mode_select = 3'h7;
    osc_mode = OSC_RC;
    void'($urandom(32'h2340));
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    wait_hi(mclk, 1, n);
    n = 0;
    while (device_reset !== 1'b0 && n < 2 * PWRT_PERIODS) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("pwrt", 1, n >= PWRT_PERIODS - 2 && n <= PWRT_PERIODS);
    rd(CPU_STATUS_OFS, CPU_STATUS_RST);
    wr(8'h80 | 8'($urandom), 8'hFF);
    rd(8'h80 | 8'($urandom), 8'h00);
    wr(CPU_STATUS_OFS, 8'h00);
    rd(CPU_STATUS_OFS, 8'h2C);
    // plain timer period from a clear
    pulse(P_CLR);
    wait_hi(timer_overflow, 70000, n);
    chk("period", 1, n >= 65535 && n <= 65537);
    chk("no_reset", 0, device_reset);
    rd(CPU_STATUS_OFS, 8'h24);
    pulse(P_CLR);
    rd(CPU_STATUS_OFS, 8'h2C);
    // rc sleep, wake by external pin only once enabled
    @(posedge mclk);
    pc <= 16'($urandom);
    pulse(P_SLP);
    #1 chk("pref_en", 1, prefetch_en);
    chk("pref", 16'(pc + 16'h0001), prefetch_addr);
    repeat (2) @(posedge mclk);
    #1 chk("asleep", 1, sleeping);
    chk("osc", 0, osc_drive_en);
    rd(CPU_STATUS_OFS, 8'h28);
    int_pin_flag <= 1'b1;
    repeat (20) @(posedge mclk);
    #1 chk("no_wake", 1, sleeping);
    int_pin_en <= 1'b1;
    wait_hi(vector_take, 10, n);
    chk("vector", 1, vector_take);
    chk("cont", 0, device_reset);
    {int_pin_flag, int_pin_en} <= 2'b00;
    // crystal mode start-up hold on wake
    osc_mode <= OSC_XT;
    pulse(P_SLP);
    repeat (3) @(posedge mclk);
    {rb_change_flag, rb_change_en} <= 2'b11;
    wait_hi(device_reset, 10, n);
    n = 0;
    while (device_reset === 1'b1 && n < 5000) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("ost", 1, n >= 1023 && n <= 1025);
    chk("awake", 0, sleeping);
    {rb_change_flag, rb_change_en} <= 2'b00;
    // already pending peripheral source, global disable set
    wr(CPU_STATUS_OFS, 8'h10);
    osc_mode <= OSC_RC;
    n = $urandom_range(PERIPH_N - 1);
    periph_wake_flag <= PERIPH_N'(1) << n;
    periph_wake_en <= PERIPH_N'(1) << n;
    pulse(P_SLP);
    n = 0;
    repeat (6) begin
      @(posedge mclk);
      #1 if (vector_take === 1'b1) n++;
    end
    chk("inline", 0, n);
    chk("no_sleep", 0, sleeping);
    rd(CPU_STATUS_OFS, 8'h38);
    {periph_wake_flag, periph_wake_en} <= '0;
    // random table traffic, judged by the checker
    repeat (40) begin
      @(posedge mclk);
      table_req <= 1'($urandom);
      fetch_internal <= 1'($urandom);
      processor_mode_select <= 3'($urandom);
    end
    processor_mode_select <= PM_PROTECTED;
    repeat (2) @(posedge mclk);
    #1 chk("prot", 1, code_protected);
    watchdog_period_select <= WPS_DISABLED;
    pulse(P_WDT);
    repeat (2) @(posedge mclk);
    #1 chk("wdt_off", 0, device_reset);
    // master clear while asleep restarts the whole device
    pulse(P_SLP);
    repeat (2) @(posedge mclk);
    pulse(P_MCLR);
    #1 chk("mclr_rst", 1, device_reset);
    n = 0;
    while (device_reset === 1'b1 && n < 2 * PWRT_PERIODS) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("rewait", 1, n >= PWRT_PERIODS - 2 && n <= PWRT_PERIODS);
    chk("mclr_awake", 0, sleeping);
    conclude();
  end
endmodule
